// [shared/imp_defines.svh]
// Offsets, field positions, reset values and encodings of the mask/poll block
`ifndef IMP_DEFINES_SVH
`define IMP_DEFINES_SVH

// Register byte offsets
`define IMP_OFF_VECTOR 8'h20
`define IMP_OFF_EOI 8'h22
`define IMP_OFF_POLL 8'h24
`define IMP_OFF_POLL_STATUS_PEEK 8'h26
`define IMP_OFF_MASK 8'h28
`define IMP_OFF_THRESH 8'h2A

// Reset values
`define IMP_THRESH_RESET 3'h7
`define IMP_MASK_RESET_MASTER 16'h07FD
`define IMP_MASK_RESET_SLAVE 16'h003D
`define IMP_VECTOR_RESET 5'h00

// Implemented mask bits per mode
`define IMP_MASK_BITS_MASTER 11'h7FD
`define IMP_MASK_BITS_SLAVE 11'h03D

// Field positions
`define IMP_PENDING_BIT 15
`define IMP_NONSPECIFIC_CLEAR_BIT 15
`define IMP_TYPE_MSB 4
`define IMP_LEVEL_MSB 2
`define IMP_VEC_LSB 3
`define IMP_VEC_MSB 7

// Source indices
`define IMP_SRC_COUNT 11
`define IMP_SRC_EXT0 4
`define IMP_SRC_EXT1 5

// Master-mode type code of source index 0; others follow by index
`define IMP_MASTER_TYPE_BASE 8'h08

`endif

// [shared/imp_pkg.sv]
// Types shared by the mask/poll/end-of-interrupt block
package imp_pkg;

  typedef enum logic {
    IMP_MASTER,
    IMP_SLAVE
  } imp_mode_type;

  typedef enum logic [1:0] {
    IMP_EOI_NONE,
    IMP_EOI_NONSPECIFIC,
    IMP_EOI_SPECIFIC,
    IMP_EOI_LEVEL
  } imp_eoi_type;

endpackage

// [verilog/imp_prio_pick.sv]
// Picks the most urgent candidate source by three-bit priority level
`timescale 1ns/1ns
module imp_prio_pick (
  // Candidates and their levels
  input wire logic [10:0] candidates,
  input wire logic [32:0] levels,
  // Winner
  output logic found,
  output logic [3:0] index,
  output logic [2:0] level
);

  // Walk downward so that on equal levels the lowest index wins
  always_comb begin
    found = 1'b0;
    index = 4'h0;
    level = 3'h7;
    for (int i = 10; i >= 0; i--) begin
      if (candidates[i] && (!found || levels[i*3 +: 3] <= level)) begin
        found = 1'b1;
        index = 4'(i);
        level = levels[i*3 +: 3];
      end
    end
  end

endmodule

// [verilog/imp_top.sv]
// Interrupt mask, poll and end-of-interrupt register block
//
// Functional notes
// - Three-bit threshold, resets seven, upper zero.
// - Sources above threshold level are blocked.
// - Level zero most urgent, seven least.
// - Mask register read/write, mirrors control masks.
// - Master mask layout, reserved bits 1, 15-11.
// - Master mask resets to 07FD.
// - Slave mask layout, reserved bits 1, 15-6.
// - Slave mask resets to 003D; here reset loads 07FD and 003D follows on the first clock after release.
// - Poll status read has no side effect.
// - Poll read acknowledges, next pending follows.
// - Bit 15 pending, bits 4-0 type.
// - Poll acknowledge never starts a handler.
// - Master END_OF_INTERRUPT_MASTER: bit15 nonspecific, else type.
// - END_OF_INTERRUPT_MASTER write clears addressed in-service flags.
// - Slave END_OF_INTERRUPT_MASTER clears level in bits 2-0.
// - Vector holds type bits 7-3 only.
// - Interrupt type is eight bits wide.
// - In-service bit set when interrupt taken.
// - In-service source raises no new request, save sources 4 and 5 under master special nesting.
//
// Design decision made here: the plain strobed port.
`include "imp_defines.svh"
`timescale 1ns/1ns
module imp_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Mode strap, sampled after reset release; special nesting input, used as it stands
  input wire logic slave_mode,
  input wire logic special_nested,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Interrupt sources
  input wire logic [10:0] source_request,
  input wire logic [32:0] source_priority_level,
  // Control-register mask bits
  input wire logic [10:0] control_mask_write,
  input wire logic [10:0] control_mask_value,
  output logic [10:0] control_mask_bit,
  // Processor side
  input wire logic int_ack,
  output logic int_request,
  output logic [7:0] int_type,
  output logic [10:0] in_service_flags
);

  imp_pkg::imp_mode_type mode;
  logic mode_loaded;
  logic [2:0] threshold_level;
  logic [10:0] source_mask;
  logic [4:0] vector_upper_bits;
  logic [10:0] in_service_bit;
  logic [10:0] implemented;
  logic [10:0] eligible;
  logic [10:0] below_threshold;
  logic [10:0] nest_bypass;
  logic pending_flag;
  logic [3:0] pending_index;
  logic [2:0] pending_level;
  logic [7:0] pending_type;
  logic serv_found;
  logic [3:0] serv_index;
  logic [2:0] serv_level;
  logic [10:0] take_set;
  logic [10:0] eoi_clear;
  logic [10:0] next_in_service;
  imp_pkg::imp_eoi_type eoi_kind;
  logic [15:0] poll_word;
  logic [15:0] next_rdata;
  logic [10:0] next_mask;
  logic poll_ack;
  logic wr_mask;
  logic wr_thresh;
  logic wr_vector;
  logic wr_eoi;

  // Reset values cut to the eleven low mask bit positions
  localparam logic [10:0] mask_reset_master = 11'(`IMP_MASK_RESET_MASTER);
  localparam logic [10:0] mask_reset_slave = 11'(`IMP_MASK_RESET_SLAVE);

  // Strobe decode
  assign wr_mask = reg_write && reg_addr == `IMP_OFF_MASK;
  assign wr_thresh = reg_write && reg_addr == `IMP_OFF_THRESH;
  assign wr_vector = reg_write && reg_addr == `IMP_OFF_VECTOR;
  assign wr_eoi = reg_write && reg_addr == `IMP_OFF_EOI;
  assign poll_ack = reg_read && reg_addr == `IMP_OFF_POLL;

  assign implemented = (mode == imp_pkg::IMP_SLAVE) ?
                       `IMP_MASK_BITS_SLAVE : `IMP_MASK_BITS_MASTER;

  // Mode is a strap: caught by the clock after release, never by reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= imp_pkg::IMP_MASTER;
      mode_loaded <= 1'b0;
    end else if (!mode_loaded) begin
      mode <= slave_mode ? imp_pkg::IMP_SLAVE : imp_pkg::IMP_MASTER;
      mode_loaded <= 1'b1;
    end
  end

  // Priority threshold
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      threshold_level <= `IMP_THRESH_RESET;
    end else if (wr_thresh) begin
      threshold_level <= reg_wdata[`IMP_LEVEL_MSB:0];
    end
  end

  // Source mask: register writes and control-register writes share it
  always_comb begin
    next_mask = source_mask;
    if (wr_mask) begin
      next_mask = reg_wdata[10:0];
    end
    for (int i = 0; i < `IMP_SRC_COUNT; i++) begin
      if (control_mask_write[i]) begin
        next_mask[i] = control_mask_value[i];
      end
    end
    next_mask = next_mask & implemented;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      source_mask <= mask_reset_master;
    end else if (!mode_loaded) begin
      // Slave layout needs its own reset value once the strap is known
      source_mask <= slave_mode ? mask_reset_slave :
                     mask_reset_master;
    end else begin
      source_mask <= next_mask;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      control_mask_bit <= mask_reset_master;
    end else if (!mode_loaded) begin
      control_mask_bit <= slave_mode ? mask_reset_slave :
                          mask_reset_master;
    end else begin
      control_mask_bit <= next_mask;
    end
  end

  // Vector base, slave mode only holds meaning
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_upper_bits <= `IMP_VECTOR_RESET;
    end else if (wr_vector) begin
      vector_upper_bits <= reg_wdata[`IMP_VEC_MSB:`IMP_VEC_LSB];
    end
  end

  // Threshold gate; level zero is the most urgent
  always_comb begin
    for (int i = 0; i < `IMP_SRC_COUNT; i++) begin
      below_threshold[i] =
        source_priority_level[i*3 +: 3] <= threshold_level;
    end
  end

  // Special nesting lets the two lowest external inputs re-request, in master mode only
  always_comb begin
    nest_bypass = 11'h000;
    if (special_nested && mode == imp_pkg::IMP_MASTER) begin
      nest_bypass[`IMP_SRC_EXT0] = 1'b1;
      nest_bypass[`IMP_SRC_EXT1] = 1'b1;
    end
  end

  // Eligible sources; a busy source stays quiet unless special nesting bypasses it
  always_comb begin
    eligible = source_request & implemented & ~source_mask;
    eligible = eligible & below_threshold;
    eligible = eligible & (~in_service_bit | nest_bypass);
  end

  imp_prio_pick u_pending_pick (
    .candidates(eligible),
    .levels(source_priority_level),
    .found(pending_flag),
    .index(pending_index),
    .level(pending_level)
  );

  imp_prio_pick u_service_pick (
    .candidates(in_service_bit),
    .levels(source_priority_level),
    .found(serv_found),
    .index(serv_index),
    .level(serv_level)
  );

  // Type of the winning request, eight bits wide
  always_comb begin
    if (mode == imp_pkg::IMP_SLAVE) begin
      pending_type = {vector_upper_bits, pending_level};
    end else begin
      pending_type = `IMP_MASTER_TYPE_BASE + {4'h0, pending_index};
    end
  end

  // Poll word: type only carries meaning while pending is set
  always_comb begin
    poll_word = 16'h0000;
    poll_word[`IMP_PENDING_BIT] = pending_flag;
    if (pending_flag) begin
      poll_word[`IMP_TYPE_MSB:0] = pending_type[`IMP_TYPE_MSB:0];
    end
  end

  // Taking an interrupt, by the processor or by a poll read
  always_comb begin
    take_set = 11'h000;
    if (pending_flag && (int_ack || poll_ack)) begin
      take_set[pending_index] = 1'b1;
    end
  end

  // End-of-interrupt decode
  always_comb begin
    eoi_kind = imp_pkg::IMP_EOI_NONE;
    if (wr_eoi) begin
      if (mode == imp_pkg::IMP_SLAVE) begin
        eoi_kind = imp_pkg::IMP_EOI_LEVEL;
      end else if (reg_wdata[`IMP_NONSPECIFIC_CLEAR_BIT]) begin
        eoi_kind = imp_pkg::IMP_EOI_NONSPECIFIC;
      end else begin
        eoi_kind = imp_pkg::IMP_EOI_SPECIFIC;
      end
    end
  end

  always_comb begin
    eoi_clear = 11'h000;
    unique case (eoi_kind)
      imp_pkg::IMP_EOI_NONE: begin
        eoi_clear = 11'h000;
      end
      imp_pkg::IMP_EOI_NONSPECIFIC: begin
        // Most urgent in-service source is the one being finished
        if (serv_found) begin
          eoi_clear[serv_index] = 1'b1;
        end
      end
      imp_pkg::IMP_EOI_SPECIFIC: begin
        for (int i = 0; i < `IMP_SRC_COUNT; i++) begin
          if (`IMP_MASTER_TYPE_BASE + 8'(i) ==
              {3'h0, reg_wdata[`IMP_TYPE_MSB:0]}) begin
            eoi_clear[i] = 1'b1;
          end
        end
      end
      imp_pkg::IMP_EOI_LEVEL: begin
        // Upper bits are written as zero by software and ignored here
        for (int i = 0; i < `IMP_SRC_COUNT; i++) begin
          if (source_priority_level[i*3 +: 3] ==
              reg_wdata[`IMP_LEVEL_MSB:0]) begin
            eoi_clear[i] = 1'b1;
          end
        end
      end
    endcase
  end

  // In-service flags: a take in the same cycle as a clear wins
  always_comb begin
    next_in_service = (in_service_bit & ~eoi_clear) | take_set;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_service_bit <= 11'h000;
    end else begin
      in_service_bit <= next_in_service;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_service_flags <= 11'h000;
    end else begin
      in_service_flags <= next_in_service;
    end
  end

  // Request to the processor; a poll acknowledge drops it without vectoring
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_request <= 1'b0;
      int_type <= 8'h00;
    end else begin
      int_request <= pending_flag && !int_ack && !poll_ack;
      int_type <= pending_type;
    end
  end

  // Read data, valid the cycle after the read strobe only
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_read) begin
      unique case (reg_addr)
        `IMP_OFF_THRESH: begin
          next_rdata = {13'h0000, threshold_level};
        end
        `IMP_OFF_MASK: begin
          next_rdata = {5'h00, source_mask};
        end
        `IMP_OFF_POLL_STATUS_PEEK: begin
          next_rdata = poll_word;
        end
        `IMP_OFF_POLL: begin
          next_rdata = poll_word;
        end
        `IMP_OFF_VECTOR: begin
          next_rdata = {8'h00, vector_upper_bits, 3'h0};
        end
        default: begin
          // Write-only and unmapped offsets read as zero
          next_rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// [bench/imp_chk.sv]
// Assertion checker on the ports of the mask, poll and end-of-interrupt block
`timescale 1ns/1ns
module imp_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Mode inputs
  input wire logic slave_mode,
  input wire logic special_nested,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // Processor side
  input wire logic int_ack,
  input wire logic int_request,
  input wire logic [7:0] int_type,
  input wire logic [10:0] control_mask_bit,
  input wire logic [10:0] in_service_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  thresh_upper_a: assert property ($past(reg_read) &&
    $past(reg_addr) == 8'h2A |-> reg_rdata[15:3] == 13'h0000)
    else $error("threshold upper bits not zero");
  mask_mirror_a: assert property ($past(reg_read) &&
    $past(reg_addr) == 8'h28 |-> reg_rdata == {5'h00, $past(control_mask_bit)})
    else $error("mask read differs from control mask");
  slave_layout_a: assert property (slave_mode && $past(reset_n) |->
    control_mask_bit[10:6] == 5'h00 && !control_mask_bit[1])
    else $error("slave mask reserved bit set");
  vector_zero_a: assert property ($past(reg_read) &&
    $past(reg_addr) == 8'h20 |-> reg_rdata[15:8] == 8'h00 &&
    reg_rdata[2:0] == 3'h0) else $error("vector reserved bits set");
  poll_quiet_a: assert property ($past(reg_read) &&
    ($past(reg_addr) == 8'h24 || $past(reg_addr) == 8'h26) &&
    !reg_rdata[15] |-> reg_rdata[14:0] == 15'h0000)
    else $error("idle poll word not zero");
  poll_ack_a: assert property (reg_read && reg_addr == 8'h24
    |=> !int_request) else $error("request stands after poll read");
  take_sets_a: assert property (int_ack && int_request &&
    !special_nested && !reg_write |=> !int_request &&
    $countones(in_service_flags) == $countones($past(in_service_flags)) + 1)
    else $error("take did not set one in-service bit");
  nonspecific_clear_clear_a: assert property (reg_write && reg_addr == 8'h22 &&
    reg_wdata[15] && !slave_mode && |in_service_flags && !int_ack |=>
    $countones(in_service_flags) + 1 == $countones($past(in_service_flags)))
    else $error("nonspecific clear did not clear one bit");
  eoi_no_set_a: assert property (reg_write && reg_addr == 8'h22 &&
    !int_ack |=> (in_service_flags & ~$past(in_service_flags)) == 11'h000)
    else $error("end of interrupt set a bit");
  busy_block_a: assert property (!slave_mode && int_request &&
    !special_nested && $past(reset_n) |->
    !in_service_flags[int_type[3:0] - 4'h8])
    else $error("request from in-service source");

  cover property (int_ack && int_request);
  cover property (reg_read && reg_addr == 8'h24 && int_request);
  cover property (reg_write && reg_addr == 8'h22 && reg_wdata[15]);
  cover property (special_nested && reg_read && reg_addr == 8'h24 &&
    in_service_flags[4]);
endmodule

bind imp_top imp_chk u_chk (.clk, .reset_n, .slave_mode, .special_nested,
  .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .int_ack,
  .int_request, .int_type, .control_mask_bit, .in_service_flags);

// [bench/imp_cpu_model.sv]
// Processor core stand-in that takes interrupts as they are reported
`timescale 1ns/1ns
module imp_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bench control
  input wire logic take_en,
  input wire logic [3:0] take_delay,
  // Controller side
  input wire logic int_request,
  input wire logic [7:0] int_type,
  output logic int_ack,
  output logic [7:0] taken_type,
  output int taken_count
);
  int wait_cnt;

  // Delay lets slow takes happen; ack never repeats while request falls
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_ack <= 1'b0;
      taken_type <= 8'h00;
      taken_count <= 0;
      wait_cnt <= 0;
    end else if (int_ack) begin
      int_ack <= 1'b0;
    end else if (take_en && int_request) begin
      if (wait_cnt >= take_delay) begin
        int_ack <= 1'b1;
        taken_type <= int_type;
        taken_count <= taken_count + 1;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end else begin
      wait_cnt <= 0;
    end
  end
endmodule

// [bench/imp_top_tb.sv]
// Self-checking bench for the mask, poll and end-of-interrupt block
`include "imp_defines.svh"
`timescale 1ns/1ns
module imp_top_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic slave_mode = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic special_nested = 1'b0;
  logic [10:0] ctl_wr = 11'h000;
  logic [10:0] ctl_val = 11'h000;
  logic [10:0] source_request = 11'h000;
  logic [32:0] source_priority_level = 33'h0;
  logic take_en = 1'b0;
  logic [3:0] take_delay = 4'h0;
  logic [15:0] reg_rdata, d;
  logic int_ack, int_request;
  logic [7:0] int_type, taken_type;
  logic [10:0] control_mask_bit, in_service_flags;
  logic [63:0] lv;
  int taken_count, mask, thresh, isv, vec, w;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  imp_top DUT (.clk, .reset_n, .slave_mode, .special_nested,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .source_request, .source_priority_level,
    .control_mask_write(ctl_wr), .control_mask_value(ctl_val),
    .control_mask_bit, .int_ack, .int_request, .int_type, .in_service_flags);
  imp_cpu_model cpu (.clk, .reset_n, .take_en, .take_delay, .int_request,
    .int_type, .int_ack, .taken_type, .taken_count);

  function automatic int lvl(int i);
    return (source_priority_level >> (3 * i)) & 7;
  endfunction
  // Lowest level wins, ties go to the lowest index
  function automatic int win();
    int b = -1;
    int nest = (special_nested && !slave_mode) ? 'h030 : 0;
    int ok = source_request & (slave_mode ? 'h03D : 'h7FD) & ~mask
             & ~(isv & ~nest);
    for (int i = 0; i < 11; i++)
      if (((ok >> i) & 1) && lvl(i) <= thresh && (b < 0 || lvl(i) < lvl(b)))
        b = i;
    return b;
  endfunction
  function automatic logic [15:0] pword(int b);
    int t = slave_mode ? ((vec & 'hF8) | lvl(b)) : 8 + b;
    return (b < 0) ? 16'h0000 : 16'h8000 | (t & 'h1F);
  endfunction

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] v);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic req(logic [10:0] r, logic [32:0] l);
    @(posedge clk);
    source_request <= r;
    source_priority_level <= l;
    repeat (3) @(posedge clk);
  endtask
  task automatic do_reset(logic sm);
    reset_n <= 1'b0;
    slave_mode <= sm;
    special_nested <= 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    mask = sm ? 'h03D : 'h7FD;
    thresh = 7;
    isv = 0;
    vec = 0;
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(61));
    do_reset(1'b0);
    rd(`IMP_OFF_THRESH);
    chk("threshold", 16'h0007, d);
    rd(`IMP_OFF_MASK);
    chk("mask", 16'h07FD, d);
    wr(`IMP_OFF_MASK, 16'hFFFF);
    rd(`IMP_OFF_MASK);
    chk("mask", 16'h07FD, d);
    @(posedge clk);
    ctl_wr <= 11'h204;
    ctl_val <= 11'h000;
    @(posedge clk);
    ctl_wr <= 11'h000;
    rd(`IMP_OFF_MASK);
    chk("mask", 16'h05F9, d);
    chk("control mask", 16'h05F9, control_mask_bit);
    for (int k = 0; k < 24; k++) begin
      mask = $urandom & 'h7FD;
      thresh = $urandom & 7;
      lv = {$urandom, $urandom};
      wr(`IMP_OFF_MASK, mask[15:0]);
      wr(`IMP_OFF_THRESH, 16'hFFF8 | thresh[15:0]);
      req(11'($urandom), lv[32:0]);
      rd(`IMP_OFF_THRESH);
      chk("threshold", thresh, d);
      rd(`IMP_OFF_POLL_STATUS_PEEK);
      chk("poll status", pword(win()), d);
    end
    // Poll every implemented source in turn, then the empty case
    mask = 0;
    thresh = 7;
    wr(`IMP_OFF_MASK, 16'h0000);
    wr(`IMP_OFF_THRESH, 16'h0007);
    lv = {$urandom, $urandom};
    req(11'h7FF, lv[32:0]);
    for (int k = 0; k < 11; k++) begin
      rd(`IMP_OFF_POLL_STATUS_PEEK);
      chk("poll status", pword(win()), d);
      w = win();
      rd(`IMP_OFF_POLL);
      chk("poll", pword(w), d);
      if (w >= 0)
        isv = isv | (1 << w);
      chk("in service", isv, in_service_flags);
    end
    for (int i = 0; i < 11; i++) begin
      wr(`IMP_OFF_EOI, 16'(8 + i));
      isv = isv & ~(1 << i);
      @(negedge clk);
      chk("in service", isv, in_service_flags);
    end
    // Core takes two sources, the busy one stays blocked until cleared
    req(11'h210, 33'h030001000);
    take_delay <= 4'($urandom);
    take_en <= 1'b1;
    for (int t = 0; t < 60 && taken_count < 1; t++)
      @(posedge clk);
    chk("taken type", 16'h000C, taken_type);
    for (int t = 0; t < 60 && taken_count < 2; t++)
      @(posedge clk);
    take_en <= 1'b0;
    chk("taken type", 16'h0011, taken_type);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("request", 16'h0000, int_request);
    chk("in service", 16'h0210, in_service_flags);
    wr(`IMP_OFF_EOI, 16'h8000);
    isv = 'h200;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("in service", 16'h0200, in_service_flags);
    rd(`IMP_OFF_POLL_STATUS_PEEK);
    chk("poll status", pword(win()), d);
    // Special nesting lets a busy external input show pending again in the poll status
    @(posedge clk);
    special_nested <= 1'b1;
    w = win();
    rd(`IMP_OFF_POLL);
    chk("poll", pword(w), d);
    isv = isv | (1 << w);
    rd(`IMP_OFF_POLL_STATUS_PEEK);
    chk("poll status", pword(win()), d);
    chk("in service", 16'h0210, in_service_flags);
    wr(`IMP_OFF_EOI, 16'h000C);
    isv = 'h200;
    @(negedge clk);
    chk("in service", 16'h0200, in_service_flags);
    rd(`IMP_OFF_EOI);
    chk("eoi read", 16'h0000, d);
    // Slave layout, vector base and level clear
    req(11'h000, 33'h0);
    do_reset(1'b1);
    rd(`IMP_OFF_MASK);
    chk("mask", 16'h003D, d);
    wr(`IMP_OFF_MASK, 16'hFFFF);
    rd(`IMP_OFF_MASK);
    chk("mask", 16'h003D, d);
    wr(`IMP_OFF_VECTOR, 16'hFFFF);
    vec = 'hF8;
    rd(`IMP_OFF_VECTOR);
    chk("vector", 16'h00F8, d);
    wr(`IMP_OFF_MASK, 16'h0000);
    mask = 0;
    req(11'h004, 33'h140);
    @(negedge clk);
    chk("type", 16'h00FD, int_type);
    w = win();
    rd(`IMP_OFF_POLL);
    chk("poll", pword(w), d);
    chk("in service", 16'h0004, in_service_flags);
    wr(`IMP_OFF_EOI, 16'h0005);
    @(negedge clk);
    chk("in service", 16'h0000, in_service_flags);
    tally_and_finish();
  end
endmodule
